// [design/rmb_map.vh]
// Purpose: Constants of the register-match break unit
// Assumes: Included by bare name from the design files
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef RMB_MAP_VH
`define RMB_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RMB_OFS_CMD      8'h00
`define RMB_OFS_ACC      8'h04
`define RMB_OFS_FLAGS    8'h08
`define RMB_OFS_IDX_ONE  8'h0C
`define RMB_OFS_IDX_TWO  8'h10
`define RMB_OFS_MASK     8'h14
`define RMB_OFS_STATUS   8'h18
`define RMB_OFS_IRQ_STAT 8'h1C
`define RMB_OFS_IRQ_MASK 8'h20

// ****************************************************************
// Command bits
// ****************************************************************
`define RMB_CMD_ARM_REG     0
`define RMB_CMD_CANCEL_REG  1
`define RMB_CMD_ARM_ADDR    2
`define RMB_CMD_CANCEL_ADDR 3
`define RMB_CMD_ARM_DATA    4
`define RMB_CMD_CANCEL_DATA 5
`define RMB_CMD_ARM_COMP    6
`define RMB_CMD_CANCEL_COMP 7

// ****************************************************************
// Widths and field counts
// ****************************************************************
`define RMB_ACC_W   4
`define RMB_IDX_W   12
`define RMB_FIELDS  8
`define RMB_CMP_W   34

// ****************************************************************
// Status and event bits
// ****************************************************************
`define RMB_EV_REG   0
`define RMB_EV_ADDR  1
`define RMB_EV_DATA  2
`define RMB_EV_COMP  3
`define RMB_EV_W     4

`endif

// [design/rmb_field_cmp.v]
// Purpose: Masked equality of one watched field
// Assumes: Live and set values are stable within the clock cycle
// Notes:   A masked field always reports a match
`timescale 1ns/1ps
`default_nettype none

module rmb_field_cmp #(
	parameter W = 4
) (
	// Values
	input  wire [W-1:0] i_live,
	input  wire [W-1:0] i_set,
	// Control
	input  wire         i_mask,
	// Result
	output wire         o_match
);

	assign o_match = i_mask | (i_live == i_set);

endmodule
`default_nettype wire

// [design/rmb_evt_reg.v]
// Purpose: Sticky event bits, mask and one level interrupt
// Assumes: Write-one-to-clear from software
// Notes:   A new event wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none

module rmb_evt_reg #(
	parameter N = 4
) (
	// Clock and reset
	input  wire         i_ref_clk,
	input  wire         i_rstn,
	// Events and software access
	input  wire [N-1:0] i_event,
	input  wire [N-1:0] i_clear,
	input  wire         i_mask_we,
	input  wire [N-1:0] i_mask_wd,
	// State
	output reg  [N-1:0] o_status,
	output reg  [N-1:0] o_mask,
	output wire         o_irq
);

	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_status <= {N{1'b0}};
			o_mask   <= {N{1'b0}};
		end
		else
		begin
			o_status <= (o_status & ~i_clear) | i_event;
			if (i_mask_we)
				o_mask <= i_mask_wd;
		end
	end

	assign o_irq = |(o_status & o_mask);

endmodule
`default_nettype wire

// [design/rmb_break_unit.v]
// Purpose: Register-match break comparator of a debug port
// Assumes: CPU register values and strobes synchronous to i_ref_clk
// Notes:   Address, data and compound matches come from neighbours
`timescale 1ns/1ps
`default_nettype none
`include "rmb_map.vh"

module rmb_break_unit #(
	parameter ACC_W = `RMB_ACC_W,
	parameter IDX_W = `RMB_IDX_W
) (
	// Clock and reset
	input  wire             i_ref_clk,
	input  wire             i_rstn,
	// Register port
	input  wire [7:0]       i_addr,
	input  wire [31:0]      i_wdata,
	input  wire             i_wr,
	input  wire             i_rd,
	output reg  [31:0]      o_rdata,
	// Live CPU registers
	input  wire [ACC_W-1:0] i_acc_a,
	input  wire [ACC_W-1:0] i_acc_b,
	input  wire             i_interrupt_flag,
	input  wire             i_decimal_flag,
	input  wire             i_zero_flag,
	input  wire             i_carry_flag,
	input  wire [IDX_W-1:0] i_index_one,
	input  wire [IDX_W-1:0] i_index_two,
	input  wire             i_insn_done,
	// Neighbour comparators
	input  wire             i_addr_match,
	input  wire             i_data_match,
	input  wire             i_comp_match,
	// Break outputs
	output reg              o_break,
	output wire             o_reg_armed,
	output wire             o_addr_armed,
	output wire             o_data_armed,
	output wire             o_comp_armed,
	output wire             o_irq
);

	// ****************************************************************
	// Condition storage
	// ****************************************************************
	reg  [ACC_W-1:0] set_a_r;
	reg  [ACC_W-1:0] set_b_r;
	reg  [3:0]       set_flag_r;
	reg  [IDX_W-1:0] set_x_r;
	reg  [IDX_W-1:0] set_y_r;
	reg  [7:0]       mask_r;
	reg              reg_arm_r;
	reg              addr_arm_r;
	reg              data_arm_r;
	reg              comp_arm_r;

	// One decoder for every write keeps the offset compare in one place
	function reg_wr;
		input       wr;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			reg_wr = wr && (addr == ofs);
		end
	endfunction

	wire wr_cmd   = reg_wr(i_wr, i_addr, `RMB_OFS_CMD);
	wire wr_acc   = reg_wr(i_wr, i_addr, `RMB_OFS_ACC);
	wire wr_flags = reg_wr(i_wr, i_addr, `RMB_OFS_FLAGS);
	wire wr_x     = reg_wr(i_wr, i_addr, `RMB_OFS_IDX_ONE);
	wire wr_y     = reg_wr(i_wr, i_addr, `RMB_OFS_IDX_TWO);
	wire wr_mask  = reg_wr(i_wr, i_addr, `RMB_OFS_MASK);
	wire wr_irqs  = reg_wr(i_wr, i_addr, `RMB_OFS_IRQ_STAT);
	wire wr_irqm  = reg_wr(i_wr, i_addr, `RMB_OFS_IRQ_MASK);

	function cmd_bit;
		input [31:0] d;
		input integer b;
		begin
			cmd_bit = d[b];
		end
	endfunction

	wire arm_reg   = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_ARM_REG);
	wire can_reg   = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_CANCEL_REG);
	wire arm_addr  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_ARM_ADDR);
	wire can_addr  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_CANCEL_ADDR);
	wire arm_data  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_ARM_DATA);
	wire can_data  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_CANCEL_DATA);
	wire arm_comp  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_ARM_COMP);
	wire can_comp  = wr_cmd && cmd_bit(i_wdata, `RMB_CMD_CANCEL_COMP);
	wire arm_simple = arm_reg | arm_addr | arm_data;

	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			set_a_r    <= {ACC_W{1'b0}};
			set_b_r    <= {ACC_W{1'b0}};
			set_flag_r <= 4'h0;
			set_x_r    <= {IDX_W{1'b0}};
			set_y_r    <= {IDX_W{1'b0}};
			mask_r     <= 8'hFF;
			reg_arm_r  <= 1'b0;
			addr_arm_r <= 1'b0;
			data_arm_r <= 1'b0;
			comp_arm_r <= 1'b0;
		end
		else
		begin
			// Writing a set value overwrites the single condition
			if (wr_acc)
			begin
				set_a_r <= i_wdata[ACC_W-1:0];
				set_b_r <= i_wdata[ACC_W+7:8];
			end
			if (wr_flags)
				set_flag_r <= i_wdata[3:0];
			if (wr_x)
				set_x_r <= i_wdata[IDX_W-1:0];
			if (wr_y)
				set_y_r <= i_wdata[IDX_W-1:0];
			if (wr_mask)
				mask_r <= i_wdata[7:0];
			// Compound arming wins if both kinds come in one write
			if (arm_comp)
				reg_arm_r <= 1'b0;
			else if (arm_reg)
				reg_arm_r <= 1'b1;
			else if (can_reg)
				reg_arm_r <= 1'b0;
			if (arm_comp)
			begin
				addr_arm_r <= 1'b0;
				data_arm_r <= 1'b0;
			end
			else
			begin
				if (arm_addr)
					addr_arm_r <= 1'b1;
				else if (can_addr)
					addr_arm_r <= 1'b0;
				if (arm_data)
					data_arm_r <= 1'b1;
				else if (can_data)
					data_arm_r <= 1'b0;
			end
			if (arm_comp)
				comp_arm_r <= 1'b1;
			else if (arm_simple || can_comp)
				comp_arm_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Comparators
	// ****************************************************************
	wire [7:0] fmatch;

	rmb_field_cmp #(.W(ACC_W)) u_cmp_a (
		.i_live  (i_acc_a),
		.i_set   (set_a_r),
		.i_mask  (mask_r[0]),
		.o_match (fmatch[0])
	);
	rmb_field_cmp #(.W(ACC_W)) u_cmp_b (
		.i_live  (i_acc_b),
		.i_set   (set_b_r),
		.i_mask  (mask_r[1]),
		.o_match (fmatch[1])
	);

	genvar g;
	wire [3:0] live_flags = {i_carry_flag, i_zero_flag,
		i_decimal_flag, i_interrupt_flag};
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_flag
			rmb_field_cmp #(.W(1)) u_cmp_f (
				.i_live  (live_flags[g]),
				.i_set   (set_flag_r[g]),
				.i_mask  (mask_r[2+g]),
				.o_match (fmatch[2+g])
			);
		end
	endgenerate

	rmb_field_cmp #(.W(IDX_W)) u_cmp_x (
		.i_live  (i_index_one),
		.i_set   (set_x_r),
		.i_mask  (mask_r[6]),
		.o_match (fmatch[6])
	);
	rmb_field_cmp #(.W(IDX_W)) u_cmp_y (
		.i_live  (i_index_two),
		.i_set   (set_y_r),
		.i_mask  (mask_r[7]),
		.o_match (fmatch[7])
	);

	// ****************************************************************
	// Break generation
	// ****************************************************************
	// Purely passive watch: no stall path into the CPU exists
	wire reg_hit  = reg_arm_r && i_insn_done && (&fmatch);
	wire addr_hit = addr_arm_r && i_addr_match;
	wire data_hit = data_arm_r && i_data_match;
	wire comp_hit = comp_arm_r && i_comp_match;
	wire [`RMB_EV_W-1:0] events = {comp_hit, data_hit, addr_hit, reg_hit};

	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_break <= 1'b0;
		else
			o_break <= |events;
	end

	assign o_reg_armed  = reg_arm_r;
	assign o_addr_armed = addr_arm_r;
	assign o_data_armed = data_arm_r;
	assign o_comp_armed = comp_arm_r;

	// ****************************************************************
	// Interrupt status
	// ****************************************************************
	wire [`RMB_EV_W-1:0] irq_stat;
	wire [`RMB_EV_W-1:0] irq_mask;

	rmb_evt_reg #(.N(`RMB_EV_W)) u_evt (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.i_event   (events),
		.i_clear   (wr_irqs ? i_wdata[`RMB_EV_W-1:0] : 4'h0),
		.i_mask_we (wr_irqm),
		.i_mask_wd (i_wdata[`RMB_EV_W-1:0]),
		.o_status  (irq_stat),
		.o_mask    (irq_mask),
		.o_irq     (o_irq)
	);

	// ****************************************************************
	// Read back
	// ****************************************************************
	reg  [31:0] rdata_nxt;

	// Idle cycles and unmapped offsets give zero, so read data stand
	// for exactly the one cycle after the strobe
	always @*
	begin
		rdata_nxt = 32'h0000_0000;
		if (i_rd)
		begin
			case (i_addr)
			`RMB_OFS_CMD:
				rdata_nxt = 32'h0000_0000;
			`RMB_OFS_ACC:
				rdata_nxt = {20'h00000, set_b_r, 4'h0, set_a_r};
			`RMB_OFS_FLAGS:
				rdata_nxt = {28'h0000000, set_flag_r};
			`RMB_OFS_IDX_ONE:
				rdata_nxt = {20'h00000, set_x_r};
			`RMB_OFS_IDX_TWO:
				rdata_nxt = {20'h00000, set_y_r};
			`RMB_OFS_MASK:
				rdata_nxt = {24'h000000, mask_r};
			`RMB_OFS_STATUS:
				rdata_nxt = {20'h00000, fmatch, comp_arm_r, data_arm_r,
					addr_arm_r, reg_arm_r};
			`RMB_OFS_IRQ_STAT:
				rdata_nxt = {28'h0000000, irq_stat};
			`RMB_OFS_IRQ_MASK:
				rdata_nxt = {28'h0000000, irq_mask};
			default:
				rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= 32'h0000_0000;
		else
			o_rdata <= rdata_nxt;
	end

endmodule
`default_nettype wire

// [verification/rmb_cpu_model.sv]
// Purpose: Behavioural CPU core under debug
// Assumes: Bench supplies the next register image
// Notes:   Slow mode retires an instruction every other cycle
`timescale 1ns/1ps
`default_nettype none
module rmb_cpu_model (
	// Clock, reset, control
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	input  wire logic [35:0] i_img,
	input  wire logic        i_slow,
	// Live registers
	output var  logic [35:0] o_img,
	output var  logic        o_insn_done
);
	// Never halted by a break: the target keeps running at speed
	always @(posedge i_ref_clk or negedge i_rstn)
		if (!i_rstn)
		begin
			o_img       <= 36'h0;
			o_insn_done <= 1'b0;
		end
		else
		begin
			o_img       <= i_img;
			o_insn_done <= i_slow ? !o_insn_done : 1'b1;
		end
endmodule
`default_nettype wire

// [verification/rmb_break_unit_props.sv]
// Purpose: Port-level checks of the break unit
// Assumes: Bound to the top module, one clock domain
// Notes:   Register matches are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module rmb_break_unit_props (
	// Clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_rstn,
	// Register port
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	// Break side
	input wire logic        i_addr_match,
	input wire logic        i_data_match,
	input wire logic        i_comp_match,
	input wire logic        o_break,
	input wire logic        o_reg_armed,
	input wire logic        o_addr_armed,
	input wire logic        o_data_armed,
	input wire logic        o_comp_armed,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	wire cmd = i_wr && i_addr == 8'h00;
	a_addr_hit: assert property (o_addr_armed && i_addr_match |=> o_break)
		else $error("Address hit gave no break");
	a_data_hit: assert property (o_data_armed && i_data_match |=> o_break)
		else $error("Data hit gave no break");
	a_quiet_idle: assert property (!o_reg_armed
		&& !(o_addr_armed && i_addr_match)
		&& !(o_data_armed && i_data_match) && !(o_comp_armed && i_comp_match)
		|=> !o_break) else $error("Break without armed hit");
	a_cancel_reg: assert property (cmd && i_wdata[1]
		&& !i_wdata[0] |=> !o_reg_armed)
		else $error("Cancel left register break armed");
	a_comp_wins: assert property (cmd && i_wdata[6] |=> o_comp_armed
		&& !o_reg_armed && !o_addr_armed) else $error("Compound arm kept others");
	a_arm_clears: assert property (cmd
		&& |{i_wdata[0], i_wdata[2], i_wdata[4]}
		&& !i_wdata[6] |=> !o_comp_armed) else $error("Compound stayed armed");
	a_arm_reg: assert property (cmd && i_wdata[0]
		&& !i_wdata[6] |=> o_reg_armed)
		else $error("Register break not armed");
	a_armed_holds: assert property (o_reg_armed && !cmd |=> o_reg_armed)
		else $error("Register arm dropped alone");
	c_reg_break: cover property (o_reg_armed && o_break);
	c_comp_armed: cover property (o_comp_armed);
	c_irq: cover property (o_irq);
endmodule
`default_nettype wire

// [verification/rmb_break_unit_tb_top.sv]
// Purpose: Self-checking bench of the break unit
// Assumes: 40 MHz clock, CPU model supplies live registers
// Notes:   Set values A=C B=5 I=1 X=041 Y=030
`timescale 1ns/1ps
`default_nettype none
module rmb_break_unit_tb_top;
	logic        clk, rstn, wr, rd, slow, am, dm, cm, brk, ra, aa, da, ca;
	logic        irq, done;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic [35:0] img, live;
	logic [44:0] rows [10];
	int          err_total, checked, i, n;
	rmb_cpu_model u_rmb_cpu_model (.i_ref_clk(clk), .i_rstn(rstn),
		.i_img(img), .i_slow(slow), .o_img(live), .o_insn_done(done));
	rmb_break_unit u_rmb_break_unit (.i_ref_clk(clk), .i_rstn(rstn),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_acc_a(live[35:32]), .i_acc_b(live[31:28]),
		.i_interrupt_flag(live[27]), .i_decimal_flag(live[26]),
		.i_zero_flag(live[25]), .i_carry_flag(live[24]),
		.i_index_one(live[23:12]), .i_index_two(live[11:0]),
		.i_insn_done(done), .i_addr_match(am), .i_data_match(dm),
		.i_comp_match(cm), .o_break(brk), .o_reg_armed(ra),
		.o_addr_armed(aa), .o_data_armed(da), .o_comp_armed(ca), .o_irq(irq));
	task automatic chk(input logic [35:0] s, input logic [35:0] e);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, s, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Whole run needs well under 1000 cycles
	initial
	begin
		#100us;
		err_total++;
		test_done();
	end
	initial
	begin
		{rstn, wr, rd, slow, am, dm, cm} = 7'h0;
		addr = 8'h00;
		wdata = 32'h0;
		img = 36'h0;
		err_total = 0;
		checked = 0;
		rows = '{{8'h00, 36'hC58041030, 1'b1}, {8'h00, 36'hC58042030, 1'b0},
			{8'h40, 36'hC58042030, 1'b1}, {8'h00, 36'hD58041030, 1'b0},
			{8'h01, 36'hD58041030, 1'b1}, {8'h00, 36'hC59041030, 1'b0},
			{8'h20, 36'hC59041030, 1'b1}, {8'h80, 36'hC58041FFF, 1'b1},
			{8'h08, 36'hC50041030, 1'b0}, {8'h02, 36'hC08041030, 1'b1}};
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(8'h14);
		chk(rv, 36'hFF);
		chk({ra, aa, da, ca, brk}, 36'h0);
		wr_reg(8'h04, 32'h0000050C);
		wr_reg(8'h08, 32'h00000001);
		wr_reg(8'h0C, 32'h00000041);
		wr_reg(8'h10, 32'h00000030);
		wr_reg(8'h00, 32'h00000001);
		for (i = 0; i < 10; i++)
		begin
			wr_reg(8'h14, {24'h0, rows[i][44:37]});
			img <= rows[i][36:1];
			wait_n(2);
			chk(brk, rows[i][0]);
		end
		$display("Row tests done");
		wr_reg(8'h00, 32'h00000002);
		wait_n(2);
		chk({ra, brk}, 36'h0);
		wr_reg(8'h00, 32'h00000001);
		wr_reg(8'h0C, 32'h00000042);
		wait_n(2);
		chk(brk, 36'h0);
		@(posedge clk);
		img <= 36'hC08042030;
		wait_n(2);
		chk(brk, 36'h1);
		wr_reg(8'h00, 32'h00000014);
		img <= 36'h0;
		wait_n(2);
		chk({ra, aa, da, brk}, 36'hE);
		for (i = 0; i < 2; i++)
		begin
			@(posedge clk);
			{dm, am} <= 2'b01 << i;
			@(posedge clk);
			{dm, am} <= 2'b00;
			#1 chk(brk, 36'h1);
		end
		$display("Arm tests done");
		wr_reg(8'h00, 32'h00000040);
		rd_reg(8'h18);
		chk(rv[3:0], 36'h8);
		wr_reg(8'h00, 32'h00000001);
		wait_n(0);
		chk({ra, ca}, 36'h2);
		wr_reg(8'h20, 32'h00000000);
		rd_reg(8'h1C);
		chk({irq, rv}, 36'h7);
		wr_reg(8'h20, 32'h00000002);
		wait_n(0);
		chk(irq, 36'h1);
		wr_reg(8'h1C, 32'h00000002);
		wait_n(0);
		chk(irq, 36'h0);
		rd_reg(8'h40);
		chk(rv, 36'h0);
		$display("Irq tests done");
		@(posedge clk);
		slow <= 1'b1;
		img  <= 36'hC58042030;
		wait_n(3);
		n = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1 n += brk;
		end
		chk(36'(n), 36'h4);
		wr_reg(8'h00, 32'h00000014);
		wait_n(0);
		chk({aa, da}, 36'h3);
		wr_reg(8'h00, 32'h00000028);
		wait_n(0);
		chk({aa, da}, 36'h0);
		wr_reg(8'h00, 32'h00000040);
		@(posedge clk);
		cm <= 1'b1;
		@(posedge clk);
		cm <= 1'b0;
		#1 chk(brk, 36'h1);
		rd_reg(8'h1C);
		chk(rv, 36'hD);
		wr_reg(8'h00, 32'h00000080);
		@(posedge clk);
		cm <= 1'b1;
		@(posedge clk);
		cm <= 1'b0;
		#1 chk({ca, brk}, 36'h0);
		wr_reg(8'h00, 32'h00000015);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wait_n(2);
		chk({ra, aa, da, ca, brk}, 36'h0);
		rd_reg(8'h14);
		chk(rv, 36'hFF);
		$display("Slow and reset tests done");
		test_done();
	end
endmodule
bind rmb_break_unit rmb_break_unit_props u_rmb_break_unit_props (
	.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_addr_match(i_addr_match),
	.i_data_match(i_data_match), .i_comp_match(i_comp_match),
	.o_break(o_break), .o_reg_armed(o_reg_armed), .o_addr_armed(o_addr_armed),
	.o_data_armed(o_data_armed), .o_comp_armed(o_comp_armed), .o_irq(o_irq));
`default_nettype wire
